/* logic/ckg_pkg.sv */
// constants for the control register bytes 4 to 8 of the clock generator
`default_nettype none
package ckg_pkg;
    // command codes that select a register byte, and the value read at unmapped codes
    localparam logic [7:0] OFF_STRAP_E_FREE = 8'h04;
    localparam logic [7:0] OFF_DRIVE_MODE   = 8'h05;
    localparam logic [7:0] OFF_TEST_STOP    = 8'h06;
    localparam logic [7:0] OFF_IDENTITY     = 8'h07;
    localparam logic [7:0] OFF_SPREAD       = 8'h08;
    localparam logic [7:0] UNMAPPED_READ    = 8'h00;

    // writable bits of bytes 4, 5, 6 and 8
    localparam logic [7:0] MASK_STRAP_E_FREE = 8'h78;
    localparam logic [7:0] MASK_DRIVE_MODE   = 8'h8b;
    localparam logic [7:0] MASK_TEST_STOP    = 8'hd8;
    localparam logic [7:0] MASK_SPREAD       = 8'hf6;

    // reserved bits that read back as one
    localparam logic [7:0] ONES_STRAP_E_FREE = 8'h07;

    // reset values of the writable bits and of the strap latch
    localparam logic [7:0] RST_STRAP_E_FREE = 8'h00;
    localparam logic [7:0] RST_DRIVE_MODE   = 8'h00;
    localparam logic [7:0] RST_TEST_STOP    = 8'h18;
    localparam logic [7:0] RST_SPREAD       = 8'h06;
    localparam logic [4:0] RST_STRAPS       = 5'h00;

    // field positions, byte 4
    localparam int BIT_STRAP_E     = 7;
    localparam int BIT_DOT_PD      = 6;
    localparam int BIT_FREE_STOP_2 = 5;
    localparam int BIT_FREE_STOP_0 = 3;
    // byte 5
    localparam int BIT_SRC_STOP_HIZ = 7;
    localparam int BIT_SRC_PD_HIZ   = 3;
    localparam int BIT_CPU1_PD_HIZ  = 1;
    localparam int BIT_CPU0_PD_HIZ  = 0;
    // byte 6
    localparam int BIT_TEST_SEL   = 7;
    localparam int BIT_TEST_MODE  = 6;
    localparam int BIT_STRAP_D    = 5;
    localparam int BIT_REF_LOW    = 4;
    localparam int BIT_SW_STOP_N  = 3;
    localparam int BIT_STRAP_C    = 2;
    localparam int BIT_STRAP_B    = 1;
    localparam int BIT_STRAP_A    = 0;
    // byte 8
    localparam int BIT_CPU_DEPTH  = 7;
    localparam int BIT_CPU_PROF   = 6;
    localparam int BIT_SERIAL_REF_SPREAD_DEPTH_EN  = 5;
    localparam int BIT_SRC_DEPTH  = 4;

    // strap vector order {e, d, c, b, a}
    localparam int STRAP_E = 4;
    localparam int STRAP_D = 3;
    localparam int STRAP_C = 2;
    localparam int STRAP_B = 1;
    localparam int STRAP_A = 0;

    typedef enum logic {ST_RUN, ST_STOPPED} ckg_stop_state_type;
endpackage
`default_nettype wire

/* logic/ckg_stop_seq.sv */
// glitch-free stop and restart of the stoppable clock outputs
`timescale 1ns/1ps
`default_nettype none
module ckg_stop_seq (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    // control
    input  wire logic       i_stop_n,
    input  wire logic       i_phase_tick,
    input  wire logic [2:0] i_free_stoppable,
    input  wire logic       i_src_hiz_mode,
    // gate controls
    output logic            o_pci_run,
    output logic [2:0]      o_free_run,
    output logic            o_src_run,
    output logic            o_src_hiz
);
    ckg_pkg::ckg_stop_state_type state_reg;
    ckg_pkg::ckg_stop_state_type state_next;
    logic                        stopped_next;

    // only move at the low-phase boundary so no runt pulse is cut
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ckg_pkg::ST_RUN: begin
                if (i_phase_tick && !i_stop_n) state_next = ckg_pkg::ST_STOPPED;
            end
            ckg_pkg::ST_STOPPED: begin
                if (i_phase_tick && i_stop_n) state_next = ckg_pkg::ST_RUN;
            end
            default: state_next = ckg_pkg::ST_RUN;
        endcase
    end

    assign stopped_next = (state_next == ckg_pkg::ST_STOPPED);

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_reg  <= ckg_pkg::ST_RUN;
            o_pci_run  <= 1'b1;
            o_free_run <= 3'h7;
            o_src_run  <= 1'b1;
            o_src_hiz  <= 1'b0;
        end else begin
            state_reg  <= state_next;
            o_pci_run  <= !stopped_next;
            o_free_run <= stopped_next ? ~i_free_stoppable : 3'h7;
            o_src_run  <= !stopped_next;
            o_src_hiz  <= stopped_next && i_src_hiz_mode;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    stop_on_tick_a: assert property (
        !i_stop_n && i_phase_tick && o_pci_run |=> !o_pci_run && !o_src_run)
        else $error("stop not applied at phase tick");
    stop_waits_tick_a: assert property (
        o_pci_run && !i_phase_tick |=> o_pci_run)
        else $error("stop applied off the phase tick");
    restart_tick_a: assert property (
        i_stop_n && i_phase_tick && !o_src_run |=> o_src_run && o_pci_run)
        else $error("restart not applied at phase tick");
    restart_waits_a: assert property (
        !o_pci_run && !i_phase_tick |=> !o_pci_run)
        else $error("restart applied off the phase tick");
    stop_cycle_c: cover property (
        o_pci_run ##1 !o_pci_run ##[1:20] o_pci_run);
endmodule // ckg_stop_seq
`default_nettype wire

/* logic/ckg_ctrl_regs.sv */
// control register bytes 4 to 8: straps, stop, drive modes, spread
//
// What this block does
// - straps latched at power-good read as read-only
// - byte4 bit6 sets dot pair power-down drive
// - byte4 bits5..3 make free PCI clocks stoppable
// - byte5 bit7 tri-states SRC during software stop
// - byte5 bit3 tri-states SRC 7..1 in power-down
// - byte5 bits1,0 tri-state CPU pairs in power-down
// - byte6 bit6 test mode, bit7 picks output
// - byte6 bit4 reference strength, one means low
// - writing zero stops stoppable clocks without runts
// - writing one restarts stopped clocks without runts
// - byte8 bit7 selects CPU spread depth
// - byte8 bit6 selects CPU down or center
// - byte8 bit5 enables SRC spread, reset off
// - byte8 bit4 selects SRC spread depth
`timescale 1ns/1ps
`default_nettype none
module ckg_ctrl_regs #(
    // arbitrary identity values, not tied to any real part
    parameter logic [3:0] REVISION_CODE = 4'h1,
    parameter logic [3:0] VENDOR_CODE   = 4'h5
) (
    // clock and reset
    input  wire logic       I_CLOCK,
    input  wire logic       I_RST,
    // byte access from the serial protocol engine
    input  wire logic [7:0] I_CMD_CODE,
    input  wire logic       I_WR_STB,
    input  wire logic [7:0] I_WR_DATA,
    input  wire logic       I_RD_STB,
    output logic [7:0]      O_RD_DATA,
    output logic            O_RD_VALID,
    // pins sampled at power-good
    input  wire logic       I_POWER_GOOD_N,
    input  wire logic       I_STRAP_SEL_E,
    input  wire logic       I_STRAP_SEL_D,
    input  wire logic       I_STRAP_SEL_C,
    input  wire logic       I_STRAP_SEL_B,
    input  wire logic       I_STRAP_SEL_A,
    // low-phase boundary of the PCI clock, same clock domain
    input  wire logic       I_PCI_PHASE_TICK,
    // drive mode controls
    output logic            O_DOT_POWERDOWN_DRIVE,
    output logic [2:0]      O_FREE_PCI_STOPPABLE,
    output logic            O_SRC_STOP_TRISTATE,
    output logic            O_SRC_7_TO_1_PD_TRISTATE,
    output logic [1:0]      O_CPU_PD_TRISTATE,
    // test and reference controls
    output logic            O_TEST_MODE,
    output logic            O_TEST_SEL,
    output logic            O_REFERENCE_OUTPUT_STRENGTH,
    // spread spectrum controls
    output logic            O_CPU_SPREAD_DEPTH,
    output logic            O_CPU_SPREAD_PROFILE,
    output logic            O_SERIAL_REF_SPREAD_ENABLE,
    output logic            O_SERIAL_REF_SPREAD_DEPTH,
    // gate controls for the stoppable outputs
    output logic            O_PCI_RUN,
    output logic [2:0]      O_FREE_PCI_RUN,
    output logic            O_SRC_RUN,
    output logic            O_SRC_STOP_HIZ
);
    logic [7:0] b4_reg;
    logic [7:0] b5_reg;
    logic [7:0] b6_reg;
    logic [7:0] b8_reg;
    logic [4:0] strap_s1_reg;
    logic [4:0] strap_s2_reg;
    logic       pg_s1_reg;
    logic       pg_s2_reg;
    logic       captured_reg;
    logic [4:0] straps_reg;

    wire  [4:0] strap_pins = {I_STRAP_SEL_E, I_STRAP_SEL_D, I_STRAP_SEL_C,
                              I_STRAP_SEL_B, I_STRAP_SEL_A};
    wire        capture    = !pg_s2_reg && !captured_reg;

    // merge written bits into a byte, keeping the read-only ones
    function automatic logic [7:0] merge(input logic [7:0] old_val,
                                         input logic [7:0] wdata,
                                         input logic [7:0] mask);
        merge = (old_val & ~mask) | (wdata & mask);
    endfunction

    wire wr4 = I_WR_STB && (I_CMD_CODE == ckg_pkg::OFF_STRAP_E_FREE);
    wire wr5 = I_WR_STB && (I_CMD_CODE == ckg_pkg::OFF_DRIVE_MODE);
    wire wr6 = I_WR_STB && (I_CMD_CODE == ckg_pkg::OFF_TEST_STOP);
    wire wr8 = I_WR_STB && (I_CMD_CODE == ckg_pkg::OFF_SPREAD);

    wire [7:0] b4_next = wr4 ? merge(b4_reg, I_WR_DATA,
                                     ckg_pkg::MASK_STRAP_E_FREE) : b4_reg;
    wire [7:0] b5_next = wr5 ? merge(b5_reg, I_WR_DATA,
                                     ckg_pkg::MASK_DRIVE_MODE) : b5_reg;
    wire [7:0] b6_next = wr6 ? merge(b6_reg, I_WR_DATA,
                                     ckg_pkg::MASK_TEST_STOP) : b6_reg;
    wire [7:0] b8_next = wr8 ? merge(b8_reg, I_WR_DATA,
                                     ckg_pkg::MASK_SPREAD) : b8_reg;

    // read views; strap bits come from the latch, never from the write
    wire [7:0] view4 = (b4_reg & ckg_pkg::MASK_STRAP_E_FREE)
                     | ckg_pkg::ONES_STRAP_E_FREE
                     | {straps_reg[ckg_pkg::STRAP_E], 7'h00};
    wire [7:0] view5 = b5_reg & ckg_pkg::MASK_DRIVE_MODE;
    wire [7:0] view6 = (b6_reg & ckg_pkg::MASK_TEST_STOP)
                     | {2'h0, straps_reg[ckg_pkg::STRAP_D], 2'h0,
                        straps_reg[ckg_pkg::STRAP_C],
                        straps_reg[ckg_pkg::STRAP_B],
                        straps_reg[ckg_pkg::STRAP_A]};
    wire [7:0] view7 = {REVISION_CODE, VENDOR_CODE};
    wire [7:0] view8 = b8_reg & ckg_pkg::MASK_SPREAD;

    wire [7:0] rd_sel =
        (I_CMD_CODE == ckg_pkg::OFF_STRAP_E_FREE) ? view4 :
        (I_CMD_CODE == ckg_pkg::OFF_DRIVE_MODE)   ? view5 :
        (I_CMD_CODE == ckg_pkg::OFF_TEST_STOP)    ? view6 :
        (I_CMD_CODE == ckg_pkg::OFF_IDENTITY)     ? view7 :
        (I_CMD_CODE == ckg_pkg::OFF_SPREAD)       ? view8 :
        ckg_pkg::UNMAPPED_READ;
    wire [7:0] rd_data_next = I_RD_STB ? rd_sel : O_RD_DATA;

    // pin synchronisers; first stage feeds only the second
    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            strap_s1_reg <= 5'h00;
            strap_s2_reg <= 5'h00;
            pg_s1_reg    <= 1'b1;
            pg_s2_reg    <= 1'b1;
        end else begin
            strap_s1_reg <= strap_pins;
            strap_s2_reg <= strap_s1_reg;
            pg_s1_reg    <= I_POWER_GOOD_N;
            pg_s2_reg    <= pg_s1_reg;
        end
    end

    // latch once per power-good assertion; rearm when it drops away
    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            captured_reg <= 1'b0;
            straps_reg   <= ckg_pkg::RST_STRAPS;
        end else begin
            captured_reg <= !pg_s2_reg;
            if (capture) straps_reg <= strap_s2_reg;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            b4_reg <= ckg_pkg::RST_STRAP_E_FREE;
            b5_reg <= ckg_pkg::RST_DRIVE_MODE;
            b6_reg <= ckg_pkg::RST_TEST_STOP;
            b8_reg <= ckg_pkg::RST_SPREAD;
        end else begin
            b4_reg <= b4_next;
            b5_reg <= b5_next;
            b6_reg <= b6_next;
            b8_reg <= b8_next;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            O_RD_DATA  <= 8'h00;
            O_RD_VALID <= 1'b0;
        end else begin
            O_RD_DATA  <= rd_data_next;
            O_RD_VALID <= I_RD_STB;
        end
    end

    // controls come straight from register bits
    assign O_DOT_POWERDOWN_DRIVE = b4_reg[ckg_pkg::BIT_DOT_PD];
    assign O_FREE_PCI_STOPPABLE  =
        b4_reg[ckg_pkg::BIT_FREE_STOP_2:ckg_pkg::BIT_FREE_STOP_0];
    assign O_SRC_STOP_TRISTATE   = b5_reg[ckg_pkg::BIT_SRC_STOP_HIZ];
    assign O_SRC_7_TO_1_PD_TRISTATE = b5_reg[ckg_pkg::BIT_SRC_PD_HIZ];
    assign O_CPU_PD_TRISTATE     = {b5_reg[ckg_pkg::BIT_CPU1_PD_HIZ],
                                    b5_reg[ckg_pkg::BIT_CPU0_PD_HIZ]};
    assign O_TEST_MODE           = b6_reg[ckg_pkg::BIT_TEST_MODE];
    assign O_TEST_SEL            = b6_reg[ckg_pkg::BIT_TEST_SEL];
    assign O_REFERENCE_OUTPUT_STRENGTH = b6_reg[ckg_pkg::BIT_REF_LOW];
    assign O_CPU_SPREAD_DEPTH    = b8_reg[ckg_pkg::BIT_CPU_DEPTH];
    assign O_CPU_SPREAD_PROFILE  = b8_reg[ckg_pkg::BIT_CPU_PROF];
    assign O_SERIAL_REF_SPREAD_ENABLE = b8_reg[ckg_pkg::BIT_SERIAL_REF_SPREAD_DEPTH_EN];
    assign O_SERIAL_REF_SPREAD_DEPTH  = b8_reg[ckg_pkg::BIT_SRC_DEPTH];

    // stop bit acts only at the phase boundary, trading a little latency
    ckg_stop_seq u_stop (
        .i_clk            (I_CLOCK),
        .i_rst            (I_RST),
        .i_stop_n         (b6_reg[ckg_pkg::BIT_SW_STOP_N]),
        .i_phase_tick     (I_PCI_PHASE_TICK),
        .i_free_stoppable (O_FREE_PCI_STOPPABLE),
        .i_src_hiz_mode   (O_SRC_STOP_TRISTATE),
        .o_pci_run        (O_PCI_RUN),
        .o_free_run       (O_FREE_PCI_RUN),
        .o_src_run        (O_SRC_RUN),
        .o_src_hiz        (O_SRC_STOP_HIZ)
    );

    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (I_RST);

    strap_readback_a: assert property (
        I_RD_STB && I_CMD_CODE == ckg_pkg::OFF_TEST_STOP |=>
        O_RD_DATA[5] == $past(straps_reg[3]) &&
        O_RD_DATA[2:0] == $past(straps_reg[2:0]))
        else $error("strap bits misread in byte 6");
    strap_hold_a: assert property (
        captured_reg && !pg_s2_reg |=> $stable(straps_reg))
        else $error("straps changed after latching");
    dot_mode_a: assert property (
        wr4 |=> O_DOT_POWERDOWN_DRIVE == $past(I_WR_DATA[6]))
        else $error("dot power-down mode not written");
    free_stop_a: assert property (
        wr4 |=> O_FREE_PCI_STOPPABLE == $past(I_WR_DATA[5:3]))
        else $error("free clock stoppable bits not written");
    src_stop_mode_a: assert property (
        wr5 |=> O_SRC_STOP_TRISTATE == $past(I_WR_DATA[7]))
        else $error("src stop mode not written");
    src_pd_mode_a: assert property (
        wr5 |=> O_SRC_7_TO_1_PD_TRISTATE == $past(I_WR_DATA[3]))
        else $error("src power-down mode not written");
    cpu_pd_mode_a: assert property (
        wr5 |=> O_CPU_PD_TRISTATE == $past(I_WR_DATA[1:0]))
        else $error("cpu power-down modes not written");
    test_ctrl_a: assert property (
        wr6 |=> {O_TEST_SEL, O_TEST_MODE} == $past(I_WR_DATA[7:6]))
        else $error("test controls not written");
    ref_strength_a: assert property (
        wr6 |=> O_REFERENCE_OUTPUT_STRENGTH == $past(I_WR_DATA[4]))
        else $error("reference strength not written");
    sw_stop_path_a: assert property (
        wr6 && !I_WR_DATA[3] ##1 !wr6 ##1 I_PCI_PHASE_TICK && !wr6
        |=> !O_PCI_RUN)
        else $error("software stop did not halt clocks");
    identity_read_a: assert property (
        I_RD_STB && I_CMD_CODE == ckg_pkg::OFF_IDENTITY |=>
        O_RD_VALID && O_RD_DATA == {REVISION_CODE, VENDOR_CODE})
        else $error("identity byte wrong");
    cpu_spread_a: assert property (
        wr8 |=> {O_CPU_SPREAD_DEPTH, O_CPU_SPREAD_PROFILE}
                == $past(I_WR_DATA[7:6]))
        else $error("cpu spread bits not written");
    src_spread_a: assert property (
        wr8 |=> {O_SERIAL_REF_SPREAD_ENABLE, O_SERIAL_REF_SPREAD_DEPTH}
                == $past(I_WR_DATA[5:4]))
        else $error("src spread bits not written");
    unmapped_read_a: assert property (
        I_RD_STB && I_CMD_CODE > ckg_pkg::OFF_SPREAD |=> O_RD_DATA == 8'h00)
        else $error("unmapped read not zero");
    // reserved bits read fixed whatever the host wrote into them
    byte4_fixed_a: assert property (
        I_RD_STB && I_CMD_CODE == ckg_pkg::OFF_STRAP_E_FREE |=>
        O_RD_DATA[2:0] == 3'h7 && O_RD_DATA[7] == $past(straps_reg[4]))
        else $error("byte 4 strap or reserved bits misread");
    byte5_fixed_a: assert property (
        I_RD_STB && I_CMD_CODE == ckg_pkg::OFF_DRIVE_MODE |=>
        (O_RD_DATA & ~ckg_pkg::MASK_DRIVE_MODE) == 8'h00)
        else $error("byte 5 reserved bits not zero");
    byte8_fixed_a: assert property (
        I_RD_STB && I_CMD_CODE == ckg_pkg::OFF_SPREAD |=>
        O_RD_DATA[3] == 1'b0 && O_RD_DATA[0] == 1'b0)
        else $error("byte 8 reserved bits not zero");
    read_valid_a: assert property (
        I_RD_STB |=> O_RD_VALID)
        else $error("read valid missing after strobe");

    strap_latch_c: cover property (capture ##1 captured_reg);
    sw_stop_c: cover property (wr6 && !I_WR_DATA[3] ##[1:20] !O_PCI_RUN);
    restart_c: cover property (!O_PCI_RUN ##1 O_PCI_RUN);
    identity_c: cover property (I_RD_STB &&
                                I_CMD_CODE == ckg_pkg::OFF_IDENTITY);
endmodule // ckg_ctrl_regs
`default_nettype wire

/* dv/ckg_host_model.sv */
// host-side model issuing single-byte register accesses
`timescale 1ns/1ps
`default_nettype none
module ckg_host_model (
    // clock
    input  wire logic       i_clk,
    // byte access towards the register bank
    output logic [7:0]      o_cmd,
    output logic            o_wr_stb,
    output logic [7:0]      o_wr_data,
    output logic            o_rd_stb,
    input  wire logic [7:0] i_rd_data,
    input  wire logic       i_rd_valid
);
    initial begin
        o_cmd     = 8'h00;
        o_wr_stb  = 1'b0;
        o_wr_data = 8'h00;
        o_rd_stb  = 1'b0;
    end

    // reserved bits go out at their fixed values, except byte 8 bit 0, which is sent as given
    function automatic logic [7:0] fix_reserved(input logic [7:0] cmd,
                                                input logic [7:0] d);
        case (cmd)
            8'h04: return d | 8'h07;
            8'h05: return d & 8'h8b;
            8'h08: return d & 8'hf7;
            default: return d;
        endcase
    endfunction

    // gap idle cycles model a slow host; released lines show garbage
    task automatic write_byte(input logic [7:0] cmd, input logic [7:0] d,
                              input int gap);
        repeat (gap) @(posedge i_clk);
        @(posedge i_clk);
        o_cmd     <= cmd;
        o_wr_data <= fix_reserved(cmd, d);
        o_wr_stb  <= 1'b1;
        @(posedge i_clk);
        o_wr_stb  <= 1'b0;
        o_cmd     <= ~cmd;
        o_wr_data <= ~fix_reserved(cmd, d);
        #1;
    endtask

    task automatic read_byte(input logic [7:0] cmd, input int gap,
                             output logic [7:0] d, output logic got);
        got = 1'b0;
        d = 8'h00;
        repeat (gap) @(posedge i_clk);
        @(posedge i_clk);
        o_cmd    <= cmd;
        o_rd_stb <= 1'b1;
        @(posedge i_clk);
        o_rd_stb <= 1'b0;
        o_cmd    <= ~cmd;
        for (int n = 0; n < 3 && !got; n++) begin
            #1;
            if (i_rd_valid === 1'b1) begin
                got = 1'b1;
                d = i_rd_data;
            end else begin
                @(posedge i_clk);
            end
        end
    endtask
endmodule // ckg_host_model
`default_nettype wire

/* dv/ckg_ctrl_regs_tb_top.sv */
// self-checking bench for the control register bytes 4 to 8
`timescale 1ns/1ps
`default_nettype none
module ckg_ctrl_regs_tb_top;
    // arbitrary identity values
    localparam logic [3:0] REV = 4'h2;
    localparam logic [3:0] VEN = 4'h9;

    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [7:0] cmd, wr_data, rd_data;
    logic       wr_stb, rd_stb, rd_valid;
    logic       pg_n = 1'b1;
    logic [4:0] strap = 5'h00;
    logic       tick = 1'b0;
    logic       dot_pd, src_stop_tri, src_pd_tri, test_mode, test_sel;
    logic       ref_low, cpu_depth, cpu_prof, serial_ref_spread_depth_en, src_depth;
    logic       pci_run, src_run, src_hiz;
    logic [2:0] free_stoppable, free_run;
    logic [1:0] cpu_pd_tri;
    int         error_cnt = 0;
    int         samples_checked = 0;

    always #5 clk = ~clk;

    ckg_host_model i_ckg_host_model (
        .i_clk(clk), .o_cmd(cmd), .o_wr_stb(wr_stb), .o_wr_data(wr_data),
        .o_rd_stb(rd_stb), .i_rd_data(rd_data), .i_rd_valid(rd_valid));

    ckg_ctrl_regs #(.REVISION_CODE(REV), .VENDOR_CODE(VEN)) i_ckg_ctrl_regs (
        .I_CLOCK(clk), .I_RST(rst), .I_CMD_CODE(cmd), .I_WR_STB(wr_stb),
        .I_WR_DATA(wr_data), .I_RD_STB(rd_stb), .O_RD_DATA(rd_data),
        .O_RD_VALID(rd_valid), .I_POWER_GOOD_N(pg_n),
        .I_STRAP_SEL_E(strap[4]), .I_STRAP_SEL_D(strap[3]),
        .I_STRAP_SEL_C(strap[2]), .I_STRAP_SEL_B(strap[1]),
        .I_STRAP_SEL_A(strap[0]), .I_PCI_PHASE_TICK(tick),
        .O_DOT_POWERDOWN_DRIVE(dot_pd),
        .O_FREE_PCI_STOPPABLE(free_stoppable),
        .O_SRC_STOP_TRISTATE(src_stop_tri),
        .O_SRC_7_TO_1_PD_TRISTATE(src_pd_tri),
        .O_CPU_PD_TRISTATE(cpu_pd_tri), .O_TEST_MODE(test_mode),
        .O_TEST_SEL(test_sel), .O_REFERENCE_OUTPUT_STRENGTH(ref_low),
        .O_CPU_SPREAD_DEPTH(cpu_depth), .O_CPU_SPREAD_PROFILE(cpu_prof),
        .O_SERIAL_REF_SPREAD_ENABLE(serial_ref_spread_depth_en),
        .O_SERIAL_REF_SPREAD_DEPTH(src_depth), .O_PCI_RUN(pci_run),
        .O_FREE_PCI_RUN(free_run), .O_SRC_RUN(src_run),
        .O_SRC_STOP_HIZ(src_hiz));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic rd_check(input logic [7:0] c, input logic [7:0] exp,
                            input int gap);
        logic [7:0] d;
        logic       got;
        i_ckg_host_model.read_byte(c, gap, d, got);
        check({7'h00, got}, 8'h01);
        check(d, exp);
    endtask

    task automatic finish_test();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic do_reset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
    endtask

    task automatic pulse_tick();
        @(posedge clk);
        tick <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
        #1;
    endtask

    task automatic t_reset_values();
        rd_check(8'h04, 8'h07, 0);
        rd_check(8'h05, 8'h00, 1);
        rd_check(8'h06, 8'h18, 0);
        rd_check(8'h07, {REV, VEN}, 2);
        rd_check(8'h08, 8'h06, 0);
        rd_check(8'h09, 8'h00, 0);
        check({7'h00, ref_low}, 8'h01);
        check({3'h0, pci_run, free_run, src_run}, 8'h1f);
        check({7'h00, src_hiz}, 8'h00);
    endtask

    // pins move after the latch; readback must not follow them
    task automatic t_straps();
        @(posedge clk);
        strap <= 5'h16;
        pg_n <= 1'b0;
        repeat (6) @(posedge clk);
        strap <= 5'h09;
        repeat (4) @(posedge clk);
        rd_check(8'h04, 8'h87, 0);
        rd_check(8'h06, 8'h1e, 0);
    endtask

    task automatic t_config();
        logic [7:0] pats [4];
        logic [7:0] p;
        pats = '{8'hff, 8'h00, 8'ha5, 8'h5a};
        for (int i = 0; i < 4; i++) begin
            p = pats[i];
            i_ckg_host_model.write_byte(8'h04, p, i);
            i_ckg_host_model.write_byte(8'h05, p, 0);
            i_ckg_host_model.write_byte(8'h06, p | 8'h08, 0);
            i_ckg_host_model.write_byte(8'h08, p, 0);
            i_ckg_host_model.write_byte(8'h07, ~p, 0);
            check({7'h00, dot_pd}, {7'h00, p[6]});
            check({5'h00, free_stoppable}, {5'h00, p[5:3]});
            check({7'h00, src_stop_tri}, {7'h00, p[7]});
            check({7'h00, src_pd_tri}, {7'h00, p[3]});
            check({6'h00, cpu_pd_tri}, {6'h00, p[1:0]});
            check({6'h00, test_mode, test_sel}, {6'h00, p[6], p[7]});
            check({7'h00, ref_low}, {7'h00, p[4]});
            check({7'h00, cpu_depth}, {7'h00, p[7]});
            check({7'h00, cpu_prof}, {7'h00, p[6]});
            check({7'h00, serial_ref_spread_depth_en}, {7'h00, p[5]});
            check({7'h00, src_depth}, {7'h00, p[4]});
            rd_check(8'h04, {1'b1, p[6:3], 3'b111}, 0);
            rd_check(8'h05, p & 8'h8b, 0);
            rd_check(8'h06, {p[7:6], 1'b0, p[4], 4'b1110}, 0);
            rd_check(8'h07, {REV, VEN}, 0);
            rd_check(8'h08, p & 8'hf6, 0);
        end
    endtask

    task automatic t_stop();
        i_ckg_host_model.write_byte(8'h04, 8'h28, 0);
        i_ckg_host_model.write_byte(8'h05, 8'h80, 0);
        i_ckg_host_model.write_byte(8'h06, 8'h10, 0);
        // no tick yet, so the clocks must keep running
        repeat (3) @(posedge clk);
        #1;
        check({3'h0, pci_run, free_run, src_run}, 8'h1f);
        pulse_tick();
        check({3'h0, pci_run, free_run, src_run}, 8'h04);
        check({7'h00, src_hiz}, 8'h01);
        i_ckg_host_model.write_byte(8'h06, 8'h18, 0);
        pulse_tick();
        check({3'h0, pci_run, free_run, src_run}, 8'h1f);
        check({7'h00, src_hiz}, 8'h00);
    endtask

    initial begin
        #200000;
        error_cnt++;
        finish_test();
    end

    initial begin
        do_reset();
        t_reset_values();
        t_straps();
        t_config();
        t_stop();
        @(posedge clk);
        pg_n <= 1'b1;
        do_reset();
        t_reset_values();
        finish_test();
    end
endmodule // ckg_ctrl_regs_tb_top
`default_nettype wire
